// ==== core/srbc_pkg.sv ====
package srbc_pkg;
    // ------------------------------------------------------------
    // clocking and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int TRAIN_MS = 20;
    localparam int TRAIN_CYC = CLK_KHZ * TRAIN_MS;
    localparam int SMB_SLOW_HZ = 100_000;
    localparam int SMB_FAST_HZ = 400_000;
    localparam int SMB_SLOW_CYC = CLK_HZ / SMB_SLOW_HZ;
    localparam int SMB_FAST_CYC = CLK_HZ / SMB_FAST_HZ;
    localparam int SMB_W = 11;
    localparam logic [3:0] HOLD_CYC = 4'hF;
    // ------------------------------------------------------------
    // pll multipliers to reach the 2.5 GHz serial clock
    // ------------------------------------------------------------
    localparam logic [4:0] MULT_REF100 = 5'h19;
    localparam logic [4:0] MULT_REF125 = 5'h14;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_OVR = 8'h08;
    localparam logic [7:0] A_STKY = 8'h0C;
    localparam logic [7:0] A_SCR = 8'h10;
    localparam logic [7:0] A_SBR = 8'h14;
    localparam int C_FUND = 0;
    localparam int C_HALT = 1;
    localparam int C_HOT = 2;
    // strap vector layout, also status bits 8:0
    localparam int SV_W = 9;
    localparam int SV_REF = 0;
    localparam int SV_CCUS = 1;
    localparam int SV_CCDS = 2;
    localparam int SV_SLOW = 3;
    localparam int SV_HALT = 4;
    localparam int SV_MODE = 5;
    localparam int ST_RSVD = 9;
    localparam int ST_HALTED = 10;
    localparam int ST_WARM = 11;
    localparam int ST_TRAIN = 12;
    localparam int ST_HALTSEEN = 13;
    localparam int OV_CCUS = 0;
    localparam int OV_CCDS = 1;
    localparam int OV_SLOW = 2;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_EEP = 4'h1;
    typedef enum logic [2:0] {
        S_FUND, S_PLL, S_EEP, S_HALT, S_RUN, S_HOT
    } srbc_state_t;
endpackage

// ==== core/srbc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module srbc_top #(
    parameter int N_DS = 2,
    parameter int TRAIN_CYC = srbc_pkg::TRAIN_CYC
) (
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // straps and reset pin
    input wire logic fundamentalResetN,
    input wire logic refclkFreqSelect,
    input wire logic commonClockUpstream,
    input wire logic commonClockDownstream,
    input wire logic masterSmbusSlowSel,
    input wire logic resetHalt,
    input wire logic [3:0] switchOpMode,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srbc_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // eeprom / slave smbus register writer
    input wire logic initWr,
    input wire logic [srbc_pkg::AW-1:0] initAddr,
    input wire logic [31:0] initData,
    output logic initRdy,
    input wire logic eepDone,
    input wire logic eepErr,
    // pll and link side
    input wire logic pllLock,
    input wire logic hotResetReq,
    output logic [4:0] pllMult,
    output logic linkTrainEn,
    output logic commonClkUs,
    output logic commonClkDs,
    output logic sscPermit,
    // reset outputs
    output logic coreRstN,
    output logic stickyRstN,
    output logic smbusEn,
    output logic msmbTick,
    output logic eepromLoad,
    output logic [N_DS-1:0] vbHotRst,
    output logic [N_DS-1:0] dsLinkHotRst
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int TW = $clog2(TRAIN_CYC + 1);
    if (N_DS < 1 || N_DS > 8) begin : g_bad_nds
        $error("N_DS must be 1 to 8");
    end
    if (TRAIN_CYC < 2) begin : g_bad_train
        $error("TRAIN_CYC must be at least 2");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    srbc_pkg::srbc_state_t state_r, state_nxt;
    logic pinS1_r, pinS2_r, pinS3_r;
    logic [srbc_pkg::SV_W-1:0] capS_r, coldS_r, strapVec;
    logic coldPend_r, warm_r, haltSeen_r;
    logic haltBit_r, pendFund_r, pendHot_r;
    logic ovrUs_r, ovrDs_r, fundSeq_r;
    logic [31:0] stky_r, scr_r;
    logic [N_DS:0] sbr_r;
    logic [3:0] holdCnt_r;
    logic [TW-1:0] cnt_r;
    logic [srbc_pkg::SMB_W-1:0] smbCnt_r;
    logic pready_r, pslverr_r, initRdy_r;
    logic [31:0] prdata_r;
    logic coreRstN_r, stickyRstN_r, smbusEn_r, msmbTick_r;
    logic eepromLoad_r, linkTrainEn_r, sscPermit_r;
    logic [4:0] pllMult_r;
    logic [N_DS-1:0] vbHotRst_r, dsLinkHotRst_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire pinLow = !pinS2_r;
    wire pinRel = pinS2_r && !pinS3_r;
    wire inFund = state_r == srbc_pkg::S_FUND;
    wire inHot = state_r == srbc_pkg::S_HOT;
    wire holdDone = holdCnt_r == 4'h0;
    wire trainDue = cnt_r == TW'(TRAIN_CYC - 1);
    wire [3:0] mode = capS_r[srbc_pkg::SV_MODE +: 4];
    wire modeEep = mode == srbc_pkg::MODE_EEP;
    wire modeRsvd = mode > srbc_pkg::MODE_EEP;
    wire access = psel && penable;
    wire apbWr = access && pready_r && pwrite;
    wire initDo = initWr && initRdy_r;
    wire wrEn = apbWr || initDo;
    wire [7:0] wrA = initDo ? initAddr : paddr;
    wire [31:0] wrD = initDo ? initData : pwdata;
    wire wCtrl = wrEn && wrA == srbc_pkg::A_CTRL;
    wire wOvr = wrEn && wrA == srbc_pkg::A_OVR;
    wire wStky = wrEn && wrA == srbc_pkg::A_STKY;
    wire wScr = wrEn && wrA == srbc_pkg::A_SCR;
    wire wSbr = wrEn && wrA == srbc_pkg::A_SBR;
    wire haltNow = pinRel ? resetHalt : capS_r[srbc_pkg::SV_HALT];
    wire leaveFund = inFund && state_nxt != srbc_pkg::S_FUND;
    wire mapped = paddr == srbc_pkg::A_CTRL || paddr == srbc_pkg::A_STAT
        || paddr == srbc_pkg::A_OVR || paddr == srbc_pkg::A_STKY
        || paddr == srbc_pkg::A_SCR || paddr == srbc_pkg::A_SBR;
    wire [srbc_pkg::SMB_W-1:0] smbLim = capS_r[srbc_pkg::SV_SLOW]
        ? srbc_pkg::SMB_W'(srbc_pkg::SMB_SLOW_CYC - 1)
        : srbc_pkg::SMB_W'(srbc_pkg::SMB_FAST_CYC - 1);
    wire [31:0] ctrlRd = {29'h0, 1'b0, haltBit_r, 1'b0};
    wire [31:0] statRd = {18'h0, haltSeen_r, linkTrainEn_r, warm_r,
        state_r == srbc_pkg::S_HALT, modeRsvd, coldS_r};
    wire [31:0] ovrRd = {29'h0, capS_r[srbc_pkg::SV_SLOW], ovrDs_r, ovrUs_r};
    wire [31:0] sbrRd = 32'(sbr_r);
    wire [31:0] rdData =
        paddr == srbc_pkg::A_CTRL ? ctrlRd :
        paddr == srbc_pkg::A_STAT ? statRd :
        paddr == srbc_pkg::A_OVR ? ovrRd :
        paddr == srbc_pkg::A_STKY ? stky_r :
        paddr == srbc_pkg::A_SCR ? scr_r :
        paddr == srbc_pkg::A_SBR ? sbrRd : 32'h0;

    assign strapVec = {switchOpMode, resetHalt, masterSmbusSlowSel,
        commonClockDownstream, commonClockUpstream, refclkFreqSelect};

    // ------------------------------------------------------------
    // reset pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_r <= 1'b0;
            pinS2_r <= 1'b0;
            pinS3_r <= 1'b0;
        end else begin
            pinS1_r <= fundamentalResetN;
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
        end
    end

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            srbc_pkg::S_FUND: begin
                if (!pinLow && holdDone)
                    state_nxt = srbc_pkg::S_PLL;
            end
            srbc_pkg::S_PLL: begin
                if (linkTrainEn_r) begin
                    if (modeEep)
                        state_nxt = srbc_pkg::S_EEP;
                    else if (haltBit_r)
                        state_nxt = srbc_pkg::S_HALT;
                    else
                        state_nxt = srbc_pkg::S_RUN;
                end
            end
            srbc_pkg::S_EEP: begin
                if (eepDone || eepErr)
                    state_nxt = (haltBit_r || eepErr)
                        ? srbc_pkg::S_HALT : srbc_pkg::S_RUN;
            end
            srbc_pkg::S_HALT: begin
                if (!haltBit_r)
                    state_nxt = srbc_pkg::S_RUN;
            end
            srbc_pkg::S_RUN: begin
                if (hotResetReq || pendHot_r)
                    state_nxt = srbc_pkg::S_HOT;
            end
            srbc_pkg::S_HOT: begin
                if (holdDone)
                    state_nxt = srbc_pkg::S_PLL;
            end
            default: state_nxt = srbc_pkg::S_FUND;
        endcase
        if (pinLow || pendFund_r)
            state_nxt = srbc_pkg::S_FUND;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            state_r <= srbc_pkg::S_FUND;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            holdCnt_r <= srbc_pkg::HOLD_CYC;
        else if (pinLow || (state_nxt != state_r
                 && (state_nxt == srbc_pkg::S_FUND
                 || state_nxt == srbc_pkg::S_HOT)))
            holdCnt_r <= srbc_pkg::HOLD_CYC;
        else if (!holdDone)
            holdCnt_r <= holdCnt_r - 4'h1;
    end

    // training deadline counted from release of reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            cnt_r <= '0;
        else if (inFund || inHot)
            cnt_r <= '0;
        else if (!linkTrainEn_r)
            cnt_r <= cnt_r + TW'(1);
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            capS_r <= '0;
            coldS_r <= '0;
            coldPend_r <= 1'b1;
            warm_r <= 1'b0;
        end else if (inFund && pinRel) begin
            capS_r <= strapVec;
            warm_r <= !coldPend_r;
            coldPend_r <= 1'b0;
            if (coldPend_r)
                coldS_r <= strapVec;
        end else if (pendFund_r) begin
            warm_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            haltBit_r <= 1'b0;
            haltSeen_r <= 1'b0;
            pendFund_r <= 1'b0;
            pendHot_r <= 1'b0;
            fundSeq_r <= 1'b1;
        end else if (inFund) begin
            haltBit_r <= leaveFund && haltNow;
            haltSeen_r <= leaveFund && haltNow;
            pendFund_r <= 1'b0;
            pendHot_r <= 1'b0;
            fundSeq_r <= 1'b1;
        end else begin
            pendFund_r <= wCtrl && wrD[srbc_pkg::C_FUND];
            pendHot_r <= !inHot && wCtrl && wrD[srbc_pkg::C_HOT];
            if (eepErr && state_r == srbc_pkg::S_EEP)
                haltBit_r <= 1'b1;
            else if (wCtrl)
                haltBit_r <= wrD[srbc_pkg::C_HALT];
            if (state_r == srbc_pkg::S_RUN)
                fundSeq_r <= 1'b0;
        end
    end

    // strap override window is the fundamental reset sequence
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ovrUs_r <= 1'b0;
            ovrDs_r <= 1'b0;
        end else if (leaveFund) begin
            ovrUs_r <= pinRel ? commonClockUpstream
                : capS_r[srbc_pkg::SV_CCUS];
            ovrDs_r <= pinRel ? commonClockDownstream
                : capS_r[srbc_pkg::SV_CCDS];
        end else if (wOvr && fundSeq_r && !inFund) begin
            ovrUs_r <= wrD[srbc_pkg::OV_CCUS];
            ovrDs_r <= wrD[srbc_pkg::OV_CCDS];
        end
    end

    // sticky survives hot reset, scratch and bus resets do not
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stky_r <= '0;
            scr_r <= '0;
            sbr_r <= '0;
        end else begin
            if (inFund)
                stky_r <= '0;
            else if (wStky)
                stky_r <= wrD;
            if (inFund || inHot)
                scr_r <= '0;
            else if (wScr)
                scr_r <= wrD;
            if (inFund || inHot)
                sbr_r <= '0;
            else if (wSbr)
                sbr_r <= wrD[N_DS:0];
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait state; init writer yields to apb
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            initRdy_r <= 1'b0;
        end else begin
            pready_r <= access && !pready_r;
            pslverr_r <= access && !pready_r && !mapped;
            initRdy_r <= !(access && !pready_r);
            if (access && !pready_r)
                prdata_r <= pwrite ? 32'h0 : rdData;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            coreRstN_r <= 1'b0;
            stickyRstN_r <= 1'b0;
            smbusEn_r <= 1'b0;
            eepromLoad_r <= 1'b0;
            linkTrainEn_r <= 1'b0;
            sscPermit_r <= 1'b0;
            pllMult_r <= srbc_pkg::MULT_REF100;
        end else begin
            coreRstN_r <= state_nxt == srbc_pkg::S_RUN;
            stickyRstN_r <= state_nxt != srbc_pkg::S_FUND;
            smbusEn_r <= state_nxt != srbc_pkg::S_FUND;
            eepromLoad_r <= state_nxt == srbc_pkg::S_EEP
                && !modeRsvd;
            if (inFund || inHot)
                linkTrainEn_r <= 1'b0;
            else if (pllLock || trainDue)
                linkTrainEn_r <= 1'b1;
            sscPermit_r <= ovrUs_r && ovrDs_r;
            pllMult_r <= capS_r[srbc_pkg::SV_REF]
                ? srbc_pkg::MULT_REF125 : srbc_pkg::MULT_REF100;
        end
    end

    // master smbus bit-rate enable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            smbCnt_r <= '0;
            msmbTick_r <= 1'b0;
        end else if (!smbusEn_r) begin
            smbCnt_r <= '0;
            msmbTick_r <= 1'b0;
        end else begin
            msmbTick_r <= smbCnt_r == smbLim;
            smbCnt_r <= smbCnt_r == smbLim ? '0
                : smbCnt_r + srbc_pkg::SMB_W'(1);
        end
    end

    // per downstream port bus resets
    for (genvar k = 0; k < N_DS; k++) begin : g_ds
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                vbHotRst_r[k] <= 1'b0;
                dsLinkHotRst_r[k] <= 1'b0;
            end else begin
                vbHotRst_r[k] <= sbr_r[0] || inHot;
                dsLinkHotRst_r[k] <= sbr_r[k+1] || inHot;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign initRdy = initRdy_r;
    assign pllMult = pllMult_r;
    assign linkTrainEn = linkTrainEn_r;
    assign commonClkUs = ovrUs_r;
    assign commonClkDs = ovrDs_r;
    assign sscPermit = sscPermit_r;
    assign coreRstN = coreRstN_r;
    assign stickyRstN = stickyRstN_r;
    assign smbusEn = smbusEn_r;
    assign msmbTick = msmbTick_r;
    assign eepromLoad = eepromLoad_r;
    assign vbHotRst = vbHotRst_r;
    assign dsLinkHotRst = dsLinkHotRst_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_pin_resets_all: assert property (
        pinLow |=> !coreRstN_r && !stickyRstN_r)
        else $error("reset pin did not reset logic");
    a_strap_capture: assert property (
        inFund && pinRel |=> capS_r == $past(strapVec))
        else $error("straps not captured at release");
    a_strap_ignored: assert property (
        !pinRel |=> $stable(capS_r))
        else $error("straps changed outside release");
    a_cold_kept: assert property (
        !coldPend_r |=> $stable(coldS_r))
        else $error("cold strap status changed");
    a_halt_holds: assert property (
        state_r == srbc_pkg::S_HALT && haltBit_r && !pinLow
        && !pendFund_r |=> state_r == srbc_pkg::S_HALT
        && smbusEn_r && !coreRstN_r)
        else $error("halt state not held");
    a_fund_sticky: assert property (
        inFund |=> stky_r == 32'h0)
        else $error("sticky not cleared");
    a_hot_sticky: assert property (
        inHot && !wStky && !pinLow && !pendFund_r
        |=> $stable(stky_r) && stickyRstN_r)
        else $error("hot reset touched sticky");
    a_train_due: assert property (
        state_r == srbc_pkg::S_PLL && trainDue |=> linkTrainEn_r)
        else $error("training not started in time");
    a_trig_compl: assert property (
        wCtrl && apbWr && wrD[srbc_pkg::C_FUND] && !inFund
        |=> !inFund && !pready_r ##1 inFund)
        else $error("warm reset before completion");
    a_rsvd_mode: assert property (
        modeRsvd |-> ##1 !eepromLoad_r)
        else $error("reserved mode started eeprom load");
    a_us_sbr: assert property (
        sbr_r[0] |=> &vbHotRst_r)
        else $error("upstream bus reset not propagated");

    c_pin_release: cover property (inFund && pinRel);
    c_halted: cover property (state_r == srbc_pkg::S_HALT);
    c_hot: cover property (inHot);
    c_eep_load: cover property (eepromLoad_r);
endmodule
`default_nettype wire

// ==== tb/srbc_platform.sv ====
`timescale 1ns/1ps
`default_nettype none
module srbc_platform (
    // bench side
    input wire logic sys_clk,
    input wire logic pinAssert,
    input wire logic [8:0] strapReq,
    input wire logic [5:0] lockDly,
    // pins toward the switch
    output logic fundamentalResetN,
    output logic [8:0] strapPins,
    output logic pllLock,
    output logic sscOn
);
    logic [5:0] lockCnt = '0;
    // ------------------------------------------------------------
    // reset pin, straps, pll lock
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        fundamentalResetN <= !pinAssert;
        strapPins[4:0] <= strapReq[4:0];
        if (pinAssert) begin
            strapPins[8:5] <= strapReq[8:5];
        end
        if (pinAssert) lockCnt <= '0;
        else if (lockCnt != 6'h3F) lockCnt <= lockCnt + 6'h01;
        pllLock <= !pinAssert && lockCnt >= lockDly;
        sscOn <= strapPins[1] && strapPins[2];
    end
endmodule
`default_nettype wire

// ==== tb/test_switch_reset_boot_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_switch_reset_boot_config;
    logic sys_clk = 0, rstn = 0, pinAssert = 1, psel = 0, penable = 0;
    logic pwrite = 0, eepDone = 0, err, seenEep;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [8:0] strapReq = '0, strapPins;
    logic [5:0] lockDly = '0;
    logic fundamentalResetN, pllLock, pready, pslverr, sscPermit, coreRstN;
    logic linkTrainEn, msmbTick, eepromLoad, ccUs, ccDs;
    logic hotReq = 0, smbusEn, stickyRstN;
    logic [1:0] vbHotRst, dsLinkHotRst;
    logic [4:0] pllMult;
    int err_count = 0, tests_run = 0, cyc = 0, t0;
    srbc_platform u_plat (.sys_clk, .pinAssert, .strapReq, .lockDly,
        .fundamentalResetN, .strapPins, .pllLock, .sscOn());
    srbc_top #(.TRAIN_CYC(20)) u_dut (
        .sys_clk, .rstn, .fundamentalResetN, .psel, .penable, .pwrite,
        .refclkFreqSelect(strapPins[0]), .commonClockUpstream(strapPins[1]),
        .commonClockDownstream(strapPins[2]), .resetHalt(strapPins[4]),
        .masterSmbusSlowSel(strapPins[3]), .switchOpMode(strapPins[8:5]),
        .paddr, .pwdata, .prdata, .pready, .pslverr, .initWr(1'b0),
        .initAddr(8'h00), .initData(32'h0000_0000), .initRdy(), .eepDone,
        .eepErr(1'b0), .pllLock, .hotResetReq(hotReq), .pllMult,
        .linkTrainEn, .commonClkUs(ccUs), .commonClkDs(ccDs), .sscPermit,
        .coreRstN, .stickyRstN, .smbusEn, .msmbTick, .eepromLoad, .vbHotRst,
        .dsLinkHotRst);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] stat(logic [8:0] s, logic h, logic w);
        return {18'h0, s[4], 1'b0, w, h, s[8:5] > 4'h1, s};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic waitRun(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            eepDone <= eepromLoad && !eepDone;
            seenEep |= eepromLoad;
            if (coreRstN === 1'b1) break;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [8:0] s;
        logic [31:0] v;
        logic [3:0] modes [4];
        logic [1:0] cc;
        modes = '{4'h0, 4'h1, 4'h2, 4'hF};
        void'($urandom(35));
        for (int i = 0; i < 6; i++) begin
            s = 9'($urandom);
            s[8:5] = i < 4 ? modes[i] : 4'($urandom);
            s[4] = !i[0];
            rstn <= 0;
            pinAssert <= 1;
            strapReq <= s;
            lockDly <= i == 1 ? 6'h3F : 6'($urandom_range(63));
            repeat (20) @(posedge sys_clk);
            rstn <= 1;
            repeat (5) @(posedge sys_clk);
            pinAssert <= 0;
            seenEep = 0;
            waitRun(400);
            strapReq <= ~s;
            apb(0, srbc_pkg::A_STAT, 0);
            chk(rd & 32'h0000_2FFF, stat(s, s[4], 0));
            chk(coreRstN, !s[4]);
            chk({smbusEn, stickyRstN}, 2'b11);
            if (s[4]) begin
                apb(1, srbc_pkg::A_OVR, {30'h0, ~s[2:1]});
                apb(1, srbc_pkg::A_CTRL, 0);
                waitRun(40);
            end
            chk(coreRstN, 1);
            chk(seenEep, s[8:5] == 4'h1);
            chk(pllMult, s[0] ? 5'h14 : 5'h19);
            cc = s[2:1] ^ {2{s[4]}};
            chk({ccUs, ccDs, sscPermit}, {cc[0], cc[1], &cc});
            chk(linkTrainEn, 1);
            @(posedge sys_clk iff msmbTick === 1'b1);
            t0 = cyc;
            @(posedge sys_clk iff msmbTick === 1'b1);
            chk(cyc - t0, s[3] ? 1250 : 312);
        end
        apb(1, srbc_pkg::A_SBR, 32'h0000_0005);
        repeat (2) @(posedge sys_clk);
        chk(vbHotRst, 2'b11);
        chk(dsLinkHotRst, 2'b10);
        hotReq <= 1;
        @(posedge sys_clk);
        hotReq <= 0;
        repeat (5) @(posedge sys_clk);
        waitRun(400);
        apb(0, srbc_pkg::A_SBR, 0);
        chk(rd, 0);
        v = $urandom;
        apb(1, srbc_pkg::A_STKY, v);
        apb(1, srbc_pkg::A_SCR, v);
        apb(1, srbc_pkg::A_CTRL, 32'h0000_0004);
        repeat (5) @(posedge sys_clk);
        waitRun(400);
        apb(0, srbc_pkg::A_STKY, 0);
        chk(rd, v);
        apb(0, srbc_pkg::A_SCR, 0);
        chk(rd, 0);
        apb(1, srbc_pkg::A_CTRL, 32'h0000_0001);
        chk(coreRstN, 1);
        repeat (5) @(posedge sys_clk);
        waitRun(400);
        apb(0, srbc_pkg::A_STAT, 0);
        chk(rd & 32'h0000_2FFF, stat(s, 0, 1));
        chk(pllMult, s[0] ? 5'h14 : 5'h19);
        apb(0, srbc_pkg::A_STKY, 0);
        chk(rd, 0);
        apb(0, 8'h18, 0);
        chk({rd[30:0], err}, 1);
        summarize();
    end
endmodule
`default_nettype wire
